// ### core/dasr_consts.vh
// Purpose: constants for the access system register bank
// Assumes: register offsets are those seen on the link's register port
// Notes: definitions only
`ifndef DASR_CONSTS_VH
`define DASR_CONSTS_VH

// ****************************************
// register offsets
// ****************************************
`define DASR_OFF_KEY_STATUS 4'h7
`define DASR_OFF_RESET_REQ 4'h8
`define DASR_OFF_CLK_DIV 4'h9
`define DASR_OFF_SYS_CTRL 4'hA
`define DASR_OFF_SYS_STATUS 4'hB
`define DASR_OFF_CRC_STATUS 4'hC

// ****************************************
// field positions
// ****************************************
`define DASR_KEY_UROW_BIT 5
`define DASR_KEY_NVM_BIT 4
`define DASR_KEY_ERASE_BIT 3
`define DASR_CTRL_DONE_BIT 1
`define DASR_CTRL_SYSTEM_CLOCK_REQUEST_BIT 0
`define DASR_STAT_RST_BIT 5
`define DASR_STAT_SLEEP_BIT 4
`define DASR_STAT_NVM_BIT 3
`define DASR_STAT_UROW_BIT 2
`define DASR_STAT_LOCK_BIT 0

// ****************************************
// values and reset values
// ****************************************
`define DASR_RST_SIGNATURE 8'h59
`define DASR_RST_RUN 8'h00
`define DASR_RESET_REQ_RST 8'h00
`define DASR_DIV_RST 2'h3
`define DASR_DIV_RESERVED 2'h0
`define DASR_DIV_16MHZ 2'h1
`define DASR_DIV_8MHZ 2'h2
`define DASR_DIV_4MHZ 2'h3
`define DASR_LOCK_RST 1'h1
`define DASR_CRC_OFF 3'h0
`define DASR_CRC_BUSY 3'h1
`define DASR_CRC_GOOD 3'h2
`define DASR_CRC_FAIL 3'h4

`endif

// ### core/dasr_sync.v
// Purpose: three-stage synchroniser for levels from the system domain
// Assumes: inputs are asynchronous to core_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module dasr_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

// ****************************************
// stages
// ****************************************
// first stage feeds only the second, never a comparison
reg [WIDTH-1:0] stage1_r;
reg [WIDTH-1:0] stage2_r;
reg [WIDTH-1:0] stage3_r;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        always @(posedge core_clk) begin
            if (rst) begin
                stage1_r[i] <= RESET_VAL[i];
                stage2_r[i] <= RESET_VAL[i];
                stage3_r[i] <= RESET_VAL[i];
                sync_out[i] <= RESET_VAL[i];
            end else if (clk_en) begin
                stage1_r[i] <= async_in[i];
                stage2_r[i] <= stage1_r[i];
                stage3_r[i] <= stage2_r[i];
                if (stage2_r[i] == stage3_r[i]) begin
                    sync_out[i] <= stage3_r[i];
                end
            end
        end
    end
endgenerate

endmodule // dasr_sync

`default_nettype wire

// ### core/dasr_regs.v
// Purpose: system-side register bank of the single pin debug link access layer
// Assumes: register port driven by the link instruction decoder on core_clk
// Notes: system status inputs arrive from another domain and are synchronised
//
// Overview of operation
// - user row write key flag, key status bit 5, sets on successful key decode.
// - programming key flag bit 4 sets on decode, clears as programming-ready sets.
// - chip erase flag bit 3 sets on decode, clears when its reset request issues.
// - system reset held while reset request holds 0x59; 0x00 releases it.
// - a requested system reset never resets this interface logic.
// - divider field picks 16, 8 or 4 MHz; 4 MHz after reset, 0 reserved.
// - writing one to user row done starts flash programming of user row data.
// - done written before data reaches RAM lets the CPU continue without it.
// - user row done writes ignored unless user row write key was decoded.
// - clock request bit held one requests system clock in any sleep mode.
// - clock request clears on interface disable, sets on programming mode enable.
// - reset active status reads one during system reset; reading clears it.
// - sleep status reads one in Idle or deeper sleep, else zero.
// - programming-ready status bit 3; debugger resets system after programming.
// - user row ready status bit 2; debugger loads RAM then sets done.
// - lock status reads one while locked, resets to one, zero after erase.
// - CRC status is one-hot: 0 off, 1 busy, 2 good, 4 failed.
// - registers reachable only through link instructions, never CPU space.
// - interface disable returns link configuration and keys to reset state.
// - reserved bits read zero and should be written zero.
`timescale 1ns/100ps
`default_nettype none
`include "dasr_consts.vh"

module dasr_regs (
    input wire core_clk,
    input wire rst,
    input wire clk_en,
    input wire link_disable,
    input wire prog_mode_enable,
    input wire key_urow_decoded,
    input wire key_nvm_decoded,
    input wire key_erase_decoded,
    input wire nvm_seq_start,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rd_valid,
    input wire sys_in_reset,
    input wire sys_sleeping,
    input wire urow_prog_ready,
    input wire device_locked,
    input wire [2:0] crc_status,
    output wire sys_reset_req,
    output wire [1:0] link_clk_sel,
    output wire sys_clk_req,
    output reg urow_program_start,
    output wire urow_session_open
);

// ****************************************
// decode helpers
// ****************************************
// register access only through the link decoder port
function hit;
    input [3:0] addr;
    input [3:0] off;
    begin
        hit = (addr == off);
    end
endfunction

wire wr_key = reg_wr_en & hit(reg_addr, `DASR_OFF_KEY_STATUS);
wire wr_reset_signature_field = reg_wr_en & hit(reg_addr, `DASR_OFF_RESET_REQ);
wire wr_div = reg_wr_en & hit(reg_addr, `DASR_OFF_CLK_DIV);
wire wr_ctrl = reg_wr_en & hit(reg_addr, `DASR_OFF_SYS_CTRL);
wire rd_status = reg_rd_en & hit(reg_addr, `DASR_OFF_SYS_STATUS);

// ****************************************
// link disable
// ****************************************
// disable clears link state only on enabled cycles, so a frozen block stays frozen
wire link_off = clk_en & link_disable;

// ****************************************
// system domain levels
// ****************************************
wire sys_in_reset_s;
wire sys_sleeping_s;
wire urow_ready_s;
wire locked_s;
wire [2:0] crc_s;

// each level filters on its own; a read may mix old and new bits of a moving group
dasr_sync #(
    .WIDTH(3),
    .RESET_VAL(3'h0)
) u_sync_lvl (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in({sys_in_reset, sys_sleeping, urow_prog_ready}),
    .sync_out({sys_in_reset_s, sys_sleeping_s, urow_ready_s})
);

// lock starts out as locked so a fresh link never sees an open part
dasr_sync #(
    .WIDTH(1),
    .RESET_VAL(`DASR_LOCK_RST)
) u_sync_lock (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(device_locked),
    .sync_out(locked_s)
);

dasr_sync #(
    .WIDTH(3),
    .RESET_VAL(`DASR_CRC_OFF)
) u_sync_crc (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(crc_status),
    .sync_out(crc_s)
);

// ****************************************
// key decode flags
// ****************************************
reg key_urow_r;
reg key_nvm_r;
reg key_erase_r;
reg nvm_ready_r;
reg [7:0] reset_signature_field_r;

wire reset_signature_field_hit = wr_reset_signature_field & (reg_wdata == `DASR_RST_SIGNATURE);
wire nvm_begin = nvm_seq_start & key_nvm_r;

// session end: debugger writes one to the flag as the last step
wire urow_end = wr_key & reg_wdata[`DASR_KEY_UROW_BIT];

// keys never outlive a disabled link, so each session must decode again
always @(posedge core_clk) begin
    if (rst || link_off) begin
        key_urow_r <= 1'b0;
        key_nvm_r <= 1'b0;
        key_erase_r <= 1'b0;
    end else if (clk_en) begin
        // a decode in the clearing cycle wins
        if (key_urow_decoded) begin
            key_urow_r <= 1'b1;
        end else if (urow_end) begin
            key_urow_r <= 1'b0;
        end
        if (key_nvm_decoded) begin
            key_nvm_r <= 1'b1;
        end else if (nvm_begin) begin
            key_nvm_r <= 1'b0;
        end
        if (key_erase_decoded) begin
            key_erase_r <= 1'b1;
        end else if (reset_signature_field_hit) begin
            key_erase_r <= 1'b0;
        end
    end
end

// ****************************************
// programming ready
// ****************************************
// held until the debugger resets the system after programming
always @(posedge core_clk) begin
    if (rst || link_off) begin
        nvm_ready_r <= 1'b0;
    end else if (clk_en) begin
        if (nvm_begin) begin
            nvm_ready_r <= 1'b1;
        end else if (reset_signature_field_hit) begin
            nvm_ready_r <= 1'b0;
        end
    end
end

// ****************************************
// reset request
// ****************************************
// any value is stored, only the signature holds the system in reset
// link disable leaves it alone, so a held system reset outlives the session
// the level is registered so the system reset tree never sees a compare glitch
reg sys_rst_r;

always @(posedge core_clk) begin
    if (rst) begin
        reset_signature_field_r <= `DASR_RESET_REQ_RST;
        sys_rst_r <= 1'b0;
    end else if (clk_en) begin
        if (wr_reset_signature_field) begin
            reset_signature_field_r <= reg_wdata;
            sys_rst_r <= reset_signature_field_hit;
        end
    end
end

// drives the system reset only; this block stays out of it
assign sys_reset_req = sys_rst_r;

// ****************************************
// clock divider select
// ****************************************
reg [1:0] div_r;

// the reserved code is refused so the link clock never goes undefined
// a disabled link comes back at the slowest, safest setting
always @(posedge core_clk) begin
    if (rst || link_off) begin
        div_r <= `DASR_DIV_RST;
    end else if (clk_en) begin
        if (wr_div && reg_wdata[1:0] != `DASR_DIV_RESERVED) begin
            div_r <= reg_wdata[1:0];
        end
    end
end

assign link_clk_sel = div_r;

// ****************************************
// system control
// ****************************************
reg system_clock_request_r;
reg done_r;

wire done_ok = wr_ctrl & key_urow_r;

always @(posedge core_clk) begin
    if (rst || link_off) begin
        system_clock_request_r <= 1'b0;
    end else if (clk_en) begin
        if (prog_mode_enable) begin
            system_clock_request_r <= 1'b1;
        end else if (wr_ctrl) begin
            system_clock_request_r <= reg_wdata[`DASR_CTRL_SYSTEM_CLOCK_REQUEST_BIT];
        end
    end
end

assign sys_clk_req = system_clock_request_r;

// the start pulse does not wait for RAM data; the CPU just goes on
// the pulse lasts one enabled cycle; the flash side must take it then
always @(posedge core_clk) begin
    if (rst || link_off) begin
        done_r <= 1'b0;
        urow_program_start <= 1'b0;
    end else if (clk_en) begin
        urow_program_start <= 1'b0;
        if (done_ok) begin
            done_r <= reg_wdata[`DASR_CTRL_DONE_BIT];
            urow_program_start <= reg_wdata[`DASR_CTRL_DONE_BIT];
        end
    end
end

assign urow_session_open = key_urow_r;

// ****************************************
// reset active status
// ****************************************
reg rst_seen_r;

wire rst_now = sys_in_reset_s | sys_reset_req;

// set wins over the clear of a read
// so a reset that starts during a status read is never lost
always @(posedge core_clk) begin
    if (rst) begin
        rst_seen_r <= 1'b0;
    end else if (clk_en) begin
        if (rst_now) begin
            rst_seen_r <= 1'b1;
        end else if (rd_status) begin
            rst_seen_r <= 1'b0;
        end
    end
end

// ****************************************
// read back
// ****************************************
reg [7:0] rd_nxt;

// system and CRC status have no write path; key status writes only clear bit 5
always @* begin
    rd_nxt = 8'h00;
    case (reg_addr)
        `DASR_OFF_KEY_STATUS: begin
            rd_nxt[`DASR_KEY_UROW_BIT] = key_urow_r;
            rd_nxt[`DASR_KEY_NVM_BIT] = key_nvm_r;
            rd_nxt[`DASR_KEY_ERASE_BIT] = key_erase_r;
        end
        `DASR_OFF_RESET_REQ: begin
            rd_nxt = reset_signature_field_r;
        end
        `DASR_OFF_CLK_DIV: begin
            rd_nxt[1:0] = div_r;
        end
        `DASR_OFF_SYS_CTRL: begin
            rd_nxt[`DASR_CTRL_DONE_BIT] = done_r;
            rd_nxt[`DASR_CTRL_SYSTEM_CLOCK_REQUEST_BIT] = system_clock_request_r;
        end
        `DASR_OFF_SYS_STATUS: begin
            rd_nxt[`DASR_STAT_RST_BIT] = rst_seen_r | rst_now;
            rd_nxt[`DASR_STAT_SLEEP_BIT] = sys_sleeping_s;
            rd_nxt[`DASR_STAT_NVM_BIT] = nvm_ready_r;
            rd_nxt[`DASR_STAT_UROW_BIT] = urow_ready_s;
            rd_nxt[`DASR_STAT_LOCK_BIT] = locked_s;
        end
        `DASR_OFF_CRC_STATUS: begin
            rd_nxt[2:0] = crc_s;
        end
        default: begin
            rd_nxt = 8'h00;
        end
    endcase
end

always @(posedge core_clk) begin
    if (rst) begin
        reg_rdata <= 8'h00;
        reg_rd_valid <= 1'b0;
    end else if (clk_en) begin
        reg_rd_valid <= reg_rd_en;
        if (reg_rd_en) begin
            reg_rdata <= rd_nxt;
        end
    end
end

endmodule // dasr_regs

`default_nettype wire

// ### test/dasr_regs_properties.sv
// Purpose: port assertions for dasr_regs
// Assumes: one clock, sync reset
// Notes: bound to dasr_regs below
`timescale 1ns/100ps
`default_nettype none
module dasr_regs_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic link_disable,
    input wire logic prog_mode_enable,
    input wire logic key_urow_decoded,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic sys_reset_req,
    input wire logic [1:0] link_clk_sel,
    input wire logic sys_clk_req,
    input wire logic urow_program_start,
    input wire logic urow_session_open
);
    // ****
    // checks
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [7:0] wd_q;
    // disable is left out of write antecedents: its priority is a design choice
    wire wa = clk_en && reg_wr_en && !link_disable;
    always_ff @(posedge core_clk) wd_q <= reg_wdata;
    property p_rd_valid; clk_en && reg_rd_en |=> reg_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_rd_zero;
        clk_en && reg_rd_en && (reg_addr < 4'h7 || reg_addr > 4'hC) |=> reg_rdata == 8'h00;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
    property p_rst_sig; wa && reg_addr == 4'h8 && reg_wdata == 8'h59 |=> sys_reset_req; endproperty
    a_rst_sig: assert property (p_rst_sig) else $error("reset not requested");
    property p_rst_res; wa && reg_addr == 4'h8 && reg_wdata != 8'h59 |=> !sys_reset_req; endproperty
    a_rst_res: assert property (p_rst_res) else $error("reset on other value");
    property p_div; wa && reg_addr == 4'h9 && reg_wdata[1:0] != 2'h0 |=> link_clk_sel == wd_q[1:0];
    endproperty
    a_div: assert property (p_div) else $error("divider not taken");
    property p_div_res; wa && reg_addr == 4'h9 && reg_wdata[1:0] == 2'h0 |=> $stable(link_clk_sel);
    endproperty
    a_div_res: assert property (p_div_res) else $error("reserved divider taken");
    property p_start;
        wa && reg_addr == 4'hA && reg_wdata[1] && urow_session_open |-> ##1 urow_program_start;
    endproperty
    a_start: assert property (p_start) else $error("done write did not start");
    property p_start_key;
        urow_program_start |-> $past(urow_session_open) && $past(reg_wr_en) && wd_q[1];
    endproperty
    a_start_key: assert property (p_start_key) else $error("start without key");
    property p_key; clk_en && key_urow_decoded && !link_disable |=> urow_session_open; endproperty
    a_key: assert property (p_key) else $error("key flag not set");
    property p_prog; clk_en && prog_mode_enable && !link_disable |=> sys_clk_req; endproperty
    a_prog: assert property (p_prog) else $error("clock request not set");
    property p_off;
        clk_en && link_disable && !prog_mode_enable
            |=> !sys_clk_req && !urow_session_open && link_clk_sel == 2'h3;
    endproperty
    a_off: assert property (p_off) else $error("disable left state");
endmodule // dasr_regs_chk
bind dasr_regs dasr_regs_chk i_dasr_regs_chk (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .link_disable(link_disable),
    .prog_mode_enable(prog_mode_enable), .key_urow_decoded(key_urow_decoded),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .sys_reset_req(sys_reset_req),
    .link_clk_sel(link_clk_sel), .sys_clk_req(sys_clk_req),
    .urow_program_start(urow_program_start), .urow_session_open(urow_session_open)
);
`default_nettype wire

// ### test/dasr_dbg_model.sv
// Purpose: debugger side of the register port
// Assumes: one byte per access
// Notes: released lines carry the inverse, never the last value
`timescale 1ns/100ps
`default_nettype none
module dasr_dbg_model (
    input wire logic core_clk,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid
);
    // ****
    // accesses
    // ****
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
    end
    // registers only reached through link accesses
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] q, output logic ok);
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        q = reg_rdata;
        ok = reg_rd_valid;
    endtask
endmodule // dasr_dbg_model
`default_nettype wire

// ### test/dasr_regs_tb.sv
// Purpose: self-checking bench for dasr_regs
// Assumes: 10 MHz core_clk, sync reset held 20 cycles
// Notes: expected state kept in ints
`timescale 1ns/100ps
`default_nettype none
module dasr_regs_tb;
    logic core_clk = 0, rst = 1, clk_en = 1, sin_rst = 0, slp = 0, urdy = 0, lck = 1;
    logic [5:0] pul = 0;
    logic [2:0] crc = 0;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, sys_reset_req, sys_clk_req, urow_program_start;
    logic urow_session_open;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [1:0] link_clk_sel;
    int mismatches = 0, compares = 0, seed = 41477;
    int ku = 0, kn = 0, ke = 0, rq = 0, dv = 3, dn = 0, cr = 0, nr = 0, stk = 0, st = 0;
    int crc_tab[$] = '{0, 1, 2, 4};
    dasr_regs i_dasr_regs (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
        .link_disable(pul[5]), .prog_mode_enable(pul[4]), .key_urow_decoded(pul[0]),
        .key_nvm_decoded(pul[1]), .key_erase_decoded(pul[2]), .nvm_seq_start(pul[3]),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .sys_in_reset(sin_rst), .sys_sleeping(slp), .urow_prog_ready(urdy),
        .device_locked(lck), .crc_status(crc), .sys_reset_req(sys_reset_req),
        .link_clk_sel(link_clk_sel), .sys_clk_req(sys_clk_req),
        .urow_program_start(urow_program_start), .urow_session_open(urow_session_open));
    dasr_dbg_model i_dasr_dbg_model (.core_clk(core_clk), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
    always #50 core_clk = ~core_clk;
    // ****
    // tasks
    // ****
    task chk(input logic [7:0] got, input int exp);
        compares++;
        if (got !== exp[7:0]) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp[7:0]);
        end
    endtask
    task outs;
        chk(sys_reset_req, rq == 'h59);
        chk(link_clk_sel, dv);
        chk(sys_clk_req, cr);
        chk(urow_session_open, ku);
        chk(urow_program_start, st);
    endtask
    // random idle gap so the port also sees slow requests
    task wr(input logic [3:0] a, input logic [7:0] d);
        repeat ($unsigned($random(seed)) % 3) @(posedge core_clk);
        i_dasr_dbg_model.wr(a, d);
        st = 0;
        if (a == 4'h7 && d[5]) ku = 0;
        if (a == 4'h8) rq = d;
        if (a == 4'h8 && d == 8'h59) {ke, nr, stk} = 3'b001;
        if (a == 4'h9 && d[1:0] != 2'h0) dv = d[1:0];
        if (a == 4'hA) cr = d[0];
        if (a == 4'hA && ku) {dn, st} = {2{32'(d[1])}};
        @(posedge core_clk);
        outs;
    endtask
    task rd(input logic [3:0] a);
        logic [7:0] e, g;
        logic ok;
        case (a)
            4'h7: e = {2'b0, ku[0], kn[0], ke[0], 3'b0};
            4'h8: e = rq[7:0];
            4'h9: e = dv[7:0];
            4'hA: e = {6'b0, dn[0], cr[0]};
            4'hB: e = {2'b0, stk[0] | sin_rst | (rq == 'h59), slp, nr[0], urdy, 1'b0, lck};
            4'hC: e = {5'b0, crc};
            default: e = 8'h00;
        endcase
        i_dasr_dbg_model.rd(a, g, ok);
        chk(ok, 1);
        chk(g, e);
        if (a == 4'hB) stk = sin_rst | (rq == 'h59);
    endtask
    task pulse(input logic [5:0] p);
        @(posedge core_clk);
        pul <= p;
        @(posedge core_clk);
        pul <= 6'h00;
        st = 0;
        if (p[0]) ku = 1;
        if (p[1]) kn = 1;
        if (p[2]) ke = 1;
        if (p[3] && kn) {kn, nr} = {32'd0, 32'd1};
        if (p[4]) cr = 1;
        if (p[5]) {ku, kn, ke, dn, cr, nr, dv} = {192'd0, 32'd3};
        @(posedge core_clk);
        outs;
    endtask
    // six cycles covers the three-stage synchronisers
    task set_sys(input logic [3:0] b, input int c);
        @(posedge core_clk);
        {sin_rst, slp, urdy, lck} <= b;
        crc <= c[2:0];
        if (b[3]) stk = 1;
        repeat (6) @(posedge core_clk);
    endtask
    task tally_and_finish;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++) rd(a[3:0]);
        for (int n = 0; n < 4; n++) begin
            wr(4'h9, 8'(3 - n));
            rd(4'h9);
        end
        // a write while the clock enable is low must leave the divider alone
        clk_en <= 1'b0;
        i_dasr_dbg_model.wr(4'h9, 8'h02);
        @(posedge core_clk);
        outs;
        clk_en <= 1'b1;
        wr(4'hB, 8'hFF);
        wr(4'hC, 8'hFF);
        wr(4'h7, 8'h18);
        wr(4'hA, 8'h03);
        for (int a = 7; a < 13; a++) rd(a[3:0]);
        pulse(6'h01);
        wr(4'hA, 8'h02);
        rd(4'hA);
        wr(4'h7, 8'h20);
        rd(4'h7);
        pulse(6'h02);
        rd(4'h7);
        pulse(6'h08);
        rd(4'h7);
        rd(4'hB);
        pulse(6'h04);
        wr(4'h8, 8'h59);
        for (int a = 7; a < 12; a++) rd(a[3:0]);
        wr(4'h8, 8'h00);
        rd(4'hB);
        rd(4'hB);
        repeat (4) begin
            v = 8'($random(seed));
            if (v == 8'h59) v = 8'h5A;
            wr(4'h8, v);
            rd(4'hB);
        end
        repeat (8) begin
            set_sys(4'($random(seed)), crc_tab[$unsigned($random(seed)) % 4]);
            rd(4'hB);
            rd(4'hB);
            rd(4'hC);
        end
        pulse(6'h10);
        wr(4'h9, 8'h02);
        pulse(6'h01);
        pulse(6'h20);
        for (int a = 7; a < 12; a++) rd(a[3:0]);
        // second reset in mid-run: reset request and sticky bit return to idle
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rq = 0;
        stk = 0;
        outs;
        for (int a = 7; a < 13; a++) rd(a[3:0]);
        tally_and_finish;
    end
    // whole sequence runs under a thousand cycles
    initial begin
        #(3000 * 100);
        mismatches++;
        tally_and_finish;
    end
endmodule // dasr_regs_tb
`default_nettype wire
